// ==== core/tap_scan_pkg.sv ====
// constants and types shared by the test access port and its helpers
package tap_scan_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int IR_WIDTH = 4;
  localparam int CHAIN_ID_WIDTH = 4;
  localparam int IDCODE_WIDTH = 32;
  localparam int BUS_WIDTH = 32;
  localparam int SIZE_WIDTH = 2;

  // ----------------------------------------
  // reset and capture values, external chain number
  // ----------------------------------------
  localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
  localparam logic [3:0] CHAIN_RESET_VALUE = 4'h3;
  localparam logic [3:0] EXT_CHAIN_ID = 4'h3;
  // arbitrary identity value, names no maker or part
  localparam logic [31:0] IDCODE_DEFAULT = 32'h0000_0001;

  // ----------------------------------------
  // instruction codes
  // ----------------------------------------
  localparam logic [3:0] INSTR_EXTEST = 4'h0;
  localparam logic [3:0] INSTR_SCAN_N = 4'h2;
  localparam logic [3:0] INSTR_SAMPLE = 4'h3;
  localparam logic [3:0] INSTR_RESTART = 4'h4;
  localparam logic [3:0] INSTR_CLAMP = 4'h5;
  localparam logic [3:0] INSTR_HIGHZ = 4'h7;
  localparam logic [3:0] INSTR_CLAMPZ = 4'h9;
  localparam logic [3:0] INSTR_INTEST = 4'hc;
  localparam logic [3:0] INSTR_IDCODE = 4'he;
  localparam logic [3:0] INSTR_BYPASS = 4'hf;

  // ----------------------------------------
  // controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_EXIT2_DR = 4'b0000,
    ST_EXIT1_DR = 4'b0001,
    ST_SHIFT_DR = 4'b0010,
    ST_PAUSE_DR = 4'b0011,
    ST_SELECT_IR = 4'b0100,
    ST_UPDATE_DR = 4'b0101,
    ST_CAPTURE_DR = 4'b0110,
    ST_SELECT_DR = 4'b0111,
    ST_EXIT2_IR = 4'b1000,
    ST_EXIT1_IR = 4'b1001,
    ST_SHIFT_IR = 4'b1010,
    ST_PAUSE_IR = 4'b1011,
    ST_RUN_IDLE = 4'b1100,
    ST_UPDATE_IR = 4'b1101,
    ST_CAPTURE_IR = 4'b1110,
    ST_TEST_RESET = 4'b1111
  } tap_state_type;

endpackage

// ==== core/scan_level_sync.sv ====
// two-flop synchroniser for slow levels entering a clock domain
`timescale 1ns/10ps
module scan_level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage_one;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage_one <= '0;
      level_out <= '0;
    end
    else
    begin
      stage_one <= level_in;
      level_out <= stage_one;
    end
  end

endmodule

// ==== core/tap_external_scan.sv ====
// test access port with external boundary-scan chain controls and bus float
`timescale 1ns/10ps

// What this block does
// RQ1: scan reset output high in reset state or while test reset pin low.
// RQ2: four-bit selected chain number, updated on falling edge in Update-DR.
// RQ3: serial data to external chain changes after rising test-clock edge.
// RQ4: return data from external chain sampled on rising test-clock edge.
// RQ5: outside logic ties the return input low when no chain exists.
// RQ6: shift clocks follow their phase only in Shift-DR with chain 3.
// RQ7: controller state shown on four-bit bus, changes on rising edge.
// RQ8: test bus float input low floats data, address and control outputs.
// RQ9: float input acts like both bus enables low, bypasses scan cells.
// RQ10: system keeps the float input high in normal operation.
// RQ11: two non-overlapping phases, high with test clock high and low.
// RQ12: in debug state debug clock and phases derive from test clock.
// RQ13: controller drives serial data and mode in, device returns data out.
// RQ14: inputs sampled on rising edge, serial output changes on falling edge.
// RQ15: serial output enable low exactly while shifting data out.
// RQ16: test reset loads chain select with 3.
// RQ17: sixteen-state controller advancing on rising edge from mode input.
module tap_external_scan
  import tap_scan_pkg::*;
#(
  parameter logic [31:0] IDCODE_VALUE = tap_scan_pkg::IDCODE_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic serial_out_enable_n,
  output logic ext_scan_reset_out,
  output logic [tap_scan_pkg::CHAIN_ID_WIDTH-1:0] selected_chain_id,
  output logic ext_scan_serial_in,
  input wire logic ext_scan_serial_return,
  output logic ext_shift_clk_phase1,
  output logic ext_shift_clk_phase2,
  output logic [3:0] tap_state_out,
  output logic test_clk_phase_one,
  output logic test_clk_phase_two,
  input wire logic debug_state_req,
  output logic debug_clk,
  input wire logic test_bus_tristate_n,
  input wire logic addr_bus_enable,
  input wire logic data_bus_enable,
  input wire logic [tap_scan_pkg::BUS_WIDTH-1:0] data_bus_value,
  input wire logic [tap_scan_pkg::BUS_WIDTH-1:0] addr_bus_value,
  input wire logic lock_value,
  input wire logic [tap_scan_pkg::SIZE_WIDTH-1:0] transfer_size_value,
  input wire logic read_write_n_value,
  input wire logic translate_n_value,
  input wire logic opcode_fetch_n_value,
  output logic [tap_scan_pkg::BUS_WIDTH-1:0] data_bus_out,
  output logic data_bus_oe,
  output logic [tap_scan_pkg::BUS_WIDTH-1:0] addr_bus_out,
  output logic addr_bus_oe,
  output logic lock_out,
  output logic [tap_scan_pkg::SIZE_WIDTH-1:0] transfer_size,
  output logic read_write_n,
  output logic translate_n,
  output logic opcode_fetch_n,
  output logic control_oe,
  output logic core_test_reset
);

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  tap_state_type state;
  tap_state_type next_state;
  logic test_rst;
  logic [IR_WIDTH-1:0] ir_shift;
  logic [IR_WIDTH-1:0] instr;
  logic bypass_bit;
  logic [IDCODE_WIDTH-1:0] idcode_shift;
  logic [CHAIN_ID_WIDTH-1:0] chain_shift;
  logic ext_return_sample;
  logic next_tdo;
  logic ext_chain_sel;
  logic ext_data_instr;
  logic shift_en_one;
  logic shift_en_two;
  logic float_instr;
  logic debug_sel;
  logic debug_gate;
  logic [2:0] core_levels;
  logic tbe_ok;
  logic highz_core;
  logic bus_float;

  // tck domain resets from either the test reset pin or the system reset
  assign test_rst = rst | ~trst_n;
  assign ext_chain_sel = (selected_chain_id == EXT_CHAIN_ID);
  assign ext_data_instr = (instr == INSTR_EXTEST) || (instr == INSTR_SAMPLE) || (instr == INSTR_INTEST);

  // --------------------------------------------------------------
  // controller state machine
  // --------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state) // RQ17
      ST_TEST_RESET: next_state = tms ? ST_TEST_RESET : ST_RUN_IDLE;
      ST_RUN_IDLE: next_state = tms ? ST_SELECT_DR : ST_RUN_IDLE;
      ST_SELECT_DR: next_state = tms ? ST_SELECT_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR: next_state = tms ? ST_SELECT_DR : ST_RUN_IDLE;
      ST_SELECT_IR: next_state = tms ? ST_TEST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR: next_state = tms ? ST_SELECT_DR : ST_RUN_IDLE;
      default: next_state = ST_TEST_RESET;
    endcase
  end

  // tms sampled on the rising edge
  always_ff @(posedge tck or posedge test_rst)
  begin
    if (test_rst)
      state <= ST_TEST_RESET;
    else
      state <= next_state; // RQ14 RQ17
  end

  assign tap_state_out = state; // RQ7

  // combinational so it asserts with no tck running
  assign ext_scan_reset_out = (state == ST_TEST_RESET) || !trst_n; // RQ1

  // --------------------------------------------------------------
  // instruction register
  // --------------------------------------------------------------
  always_ff @(posedge tck or posedge test_rst)
  begin
    if (test_rst)
      ir_shift <= IR_CAPTURE_VALUE;
    else if (state == ST_CAPTURE_IR)
      ir_shift <= IR_CAPTURE_VALUE;
    else if (state == ST_SHIFT_IR)
      ir_shift <= {tdi, ir_shift[IR_WIDTH-1:1]}; // RQ13 RQ14
  end

  // falling-edge update keeps the instruction steady across a rising edge
  always_ff @(negedge tck or posedge test_rst)
  begin
    if (test_rst)
      instr <= INSTR_IDCODE;
    else if (state == ST_TEST_RESET)
      instr <= INSTR_IDCODE;
    else if (state == ST_UPDATE_IR)
      instr <= ir_shift;
  end

  always_ff @(negedge tck or posedge test_rst)
  begin
    if (test_rst)
      float_instr <= 1'b0;
    else
      float_instr <= (instr == INSTR_HIGHZ) || (instr == INSTR_CLAMPZ);
  end

  // --------------------------------------------------------------
  // data registers
  // --------------------------------------------------------------
  always_ff @(posedge tck or posedge test_rst)
  begin
    if (test_rst)
      bypass_bit <= 1'b0;
    else if (state == ST_CAPTURE_DR)
      bypass_bit <= 1'b0;
    else if (state == ST_SHIFT_DR)
      bypass_bit <= tdi; // RQ13
  end

  always_ff @(posedge tck or posedge test_rst)
  begin
    if (test_rst)
      idcode_shift <= '0;
    else if (state == ST_CAPTURE_DR)
      idcode_shift <= IDCODE_VALUE;
    else if (state == ST_SHIFT_DR && instr == INSTR_IDCODE)
      idcode_shift <= {tdi, idcode_shift[IDCODE_WIDTH-1:1]};
  end

  always_ff @(posedge tck or posedge test_rst)
  begin
    if (test_rst)
      chain_shift <= CHAIN_RESET_VALUE;
    else if (state == ST_CAPTURE_DR)
      chain_shift <= selected_chain_id;
    else if (state == ST_SHIFT_DR && instr == INSTR_SCAN_N)
      chain_shift <= {tdi, chain_shift[CHAIN_ID_WIDTH-1:1]};
  end

  // --------------------------------------------------------------
  // scan chain select
  // --------------------------------------------------------------
  always_ff @(negedge tck or posedge test_rst)
  begin
    if (test_rst)
      selected_chain_id <= CHAIN_RESET_VALUE; // RQ16
    else if (state == ST_TEST_RESET)
      selected_chain_id <= CHAIN_RESET_VALUE; // RQ16
    else if (state == ST_UPDATE_DR && instr == INSTR_SCAN_N)
      selected_chain_id <= chain_shift; // RQ2
  end

  // --------------------------------------------------------------
  // external chain data path
  // --------------------------------------------------------------
  // launched on the rising edge, so the cells see it settled at the fall
  always_ff @(posedge tck or posedge test_rst)
  begin
    if (test_rst)
      ext_scan_serial_in <= 1'b0;
    else if (state == ST_SHIFT_DR && ext_chain_sel)
      ext_scan_serial_in <= tdi; // RQ3
  end

  // return pin is synchronous to tck, so no synchroniser here
  always_ff @(posedge tck or posedge test_rst)
  begin
    if (test_rst)
      ext_return_sample <= 1'b0;
    else
      ext_return_sample <= ext_scan_serial_return; // RQ4 RQ5
  end

  // --------------------------------------------------------------
  // serial output
  // --------------------------------------------------------------
  always_comb
  begin
    next_tdo = bypass_bit;
    if (state == ST_SHIFT_IR)
      next_tdo = ir_shift[0];
    else if (state == ST_SHIFT_DR)
    begin
      if (instr == INSTR_IDCODE)
        next_tdo = idcode_shift[0];
      else if (instr == INSTR_SCAN_N)
        next_tdo = chain_shift[0];
      else if (ext_data_instr && ext_chain_sel)
        next_tdo = ext_return_sample;
      else
        next_tdo = bypass_bit;
    end
  end

  always_ff @(negedge tck or posedge test_rst)
  begin
    if (test_rst)
    begin
      tdo <= 1'b0;
      serial_out_enable_n <= 1'b1;
    end
    else
    begin
      tdo <= next_tdo; // RQ13 RQ14
      serial_out_enable_n <= !(state == ST_SHIFT_IR || state == ST_SHIFT_DR); // RQ15
    end
  end

  // --------------------------------------------------------------
  // test clock phases and shift clocks
  // --------------------------------------------------------------
  assign test_clk_phase_one = tck; // RQ11 RQ12
  assign test_clk_phase_two = ~tck; // RQ11 RQ12

  // enables only move while their own phase is low, so no runt pulses
  always_ff @(negedge tck or posedge test_rst)
  begin
    if (test_rst)
      shift_en_one <= 1'b0;
    else
      shift_en_one <= (state == ST_SHIFT_DR) && ext_chain_sel; // RQ6
  end

  always_ff @(posedge tck or posedge test_rst)
  begin
    if (test_rst)
      shift_en_two <= 1'b0;
    else
      shift_en_two <= (next_state == ST_SHIFT_DR) && ext_chain_sel; // RQ6
  end

  assign ext_shift_clk_phase1 = test_clk_phase_one & shift_en_one; // RQ6
  assign ext_shift_clk_phase2 = test_clk_phase_two & shift_en_two; // RQ6

  // --------------------------------------------------------------
  // debug clock
  // --------------------------------------------------------------
  scan_level_sync #(
    .WIDTH(1)
  ) debug_sync (
    .clk(tck),
    .rst(test_rst),
    .level_in(debug_state_req),
    .level_out(debug_sel)
  );

  // gate changes only while tck is low; limitation: needs tck running
  always_ff @(negedge tck or posedge test_rst)
  begin
    if (test_rst)
      debug_gate <= 1'b0;
    else
      debug_gate <= debug_sel;
  end

  assign debug_clk = tck & debug_gate; // RQ12

  // --------------------------------------------------------------
  // bus float in the core domain
  // --------------------------------------------------------------
  scan_level_sync #(
    .WIDTH(3)
  ) core_sync (
    .clk(core_clk),
    .rst(rst),
    .level_in({test_bus_tristate_n, float_instr, ext_scan_reset_out}),
    .level_out(core_levels)
  );

  assign tbe_ok = core_levels[2]; // RQ10
  assign highz_core = core_levels[1];
  assign core_test_reset = core_levels[0];
  // float pin has no scan cell of its own: it bypasses the chain entirely
  assign bus_float = !tbe_ok || highz_core; // RQ9

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      data_bus_out <= '0;
      addr_bus_out <= '0;
      lock_out <= 1'b0;
      transfer_size <= '0;
      read_write_n <= 1'b0;
      translate_n <= 1'b0;
      opcode_fetch_n <= 1'b1;
    end
    else
    begin
      data_bus_out <= data_bus_value;
      addr_bus_out <= addr_bus_value;
      lock_out <= lock_value;
      transfer_size <= transfer_size_value;
      read_write_n <= read_write_n_value;
      translate_n <= translate_n_value;
      opcode_fetch_n <= opcode_fetch_n_value;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      data_bus_oe <= 1'b0;
      addr_bus_oe <= 1'b0;
      control_oe <= 1'b0;
    end
    else
    begin
      data_bus_oe <= data_bus_enable && !bus_float; // RQ8 RQ9
      addr_bus_oe <= addr_bus_enable && !bus_float; // RQ8 RQ9
      control_oe <= addr_bus_enable && !bus_float; // RQ8 RQ9
    end
  end

endmodule

// ==== tb/tap_external_scan_checker.sv ====
// assertion checker for the test access port outputs
`timescale 1ns/10ps
module tap_external_scan_checker
  import tap_scan_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic serial_out_enable_n,
  input wire logic ext_scan_reset_out,
  input wire logic [tap_scan_pkg::CHAIN_ID_WIDTH-1:0] selected_chain_id,
  input wire logic ext_scan_serial_in,
  input wire logic ext_shift_clk_phase1,
  input wire logic ext_shift_clk_phase2,
  input wire logic [3:0] tap_state_out,
  input wire logic test_clk_phase_one,
  input wire logic test_clk_phase_two,
  input wire logic test_bus_tristate_n,
  input wire logic data_bus_oe,
  input wire logic addr_bus_oe,
  input wire logic control_oe
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  wire ext_shift = tap_state_out == ST_SHIFT_DR && selected_chain_id == EXT_CHAIN_ID;
  sequence s_float_req;
    !test_bus_tristate_n [*3];
  endsequence
  sequence s_mode_high;
    tms [*5];
  endsequence
  a_reset_out: assert property (@(posedge core_clk) disable iff (rst)
    ext_scan_reset_out == (!trst_n || tap_state_out == ST_TEST_RESET)) else $error("reset out wrong");
  a_chain_reset: assert property (@(posedge core_clk) disable iff (rst)
    !trst_n |-> selected_chain_id == CHAIN_RESET_VALUE) else $error("chain not reset");
  a_chain_update: assert property (@(posedge tck) disable iff (rst || !trst_n)
    $changed(selected_chain_id) |-> tap_state_out inside {ST_UPDATE_DR, ST_TEST_RESET})
    else $error("chain changed outside update");
  a_mode_reset: assert property (@(posedge tck) disable iff (rst || !trst_n)
    s_mode_high |=> tap_state_out == ST_TEST_RESET) else $error("five ones missed reset");
  a_enable_shift: assert property (@(posedge tck) disable iff (rst || !trst_n)
    serial_out_enable_n == !(tap_state_out inside {ST_SHIFT_DR, ST_SHIFT_IR}))
    else $error("output enable wrong");
  a_serial_copy: assert property (@(posedge tck) disable iff (rst || !trst_n)
    ext_shift |=> ext_scan_serial_in == $past(tdi)) else $error("serial in not copied");
  a_phase1_gate: assert property (@(negedge tck) disable iff (rst || !trst_n)
    ext_shift_clk_phase1 == $past(ext_shift)) else $error("phase one shift clock wrong");
  a_phase2_gate: assert property (@(posedge tck) disable iff (rst || !trst_n)
    ext_shift_clk_phase2 == ext_shift) else $error("phase two shift clock wrong");
  a_clk_phases: assert property (@(posedge core_clk) disable iff (rst)
    test_clk_phase_one == tck && test_clk_phase_two == !tck) else $error("test clock phases wrong");
  a_tdo_falling: assert property (@(posedge core_clk) disable iff (rst || !trst_n)
    $changed(tdo) |-> !tck) else $error("serial out moved on rising edge");
  a_bus_float: assert property (@(posedge core_clk) disable iff (rst)
    s_float_req |=> !data_bus_oe && !addr_bus_oe && !control_oe) else $error("bus not floated");
endmodule
bind tap_external_scan tap_external_scan_checker tap_external_scan_checker_i (.*);

// ==== tb/ext_scan_cells.sv ====
// behavioural external boundary-scan cells on the phase-one shift clock
`timescale 1ns/10ps
module ext_scan_cells #(
  parameter int DEPTH = 8,
  parameter bit ATTACHED = 1
) (
  input wire logic reset_cells,
  input wire logic shift_clk1,
  input wire logic serial_in,
  output logic serial_return
);
  logic [DEPTH-1:0] cells;
  // take data as phase one ends, the moment it is promised valid
  always @(negedge shift_clk1 or posedge reset_cells)
    if (reset_cells)
      cells <= '0;
    else
      cells <= {cells[DEPTH-2:0], serial_in};
  // no chain fitted: return tied low
  assign serial_return = ATTACHED ? cells[DEPTH-1] : 1'b0;
endmodule

// ==== tb/tap_external_scan_tb.sv ====
// self-checking bench for the test access port and bus float
`timescale 1ns/10ps
module tap_external_scan_tb;
  import tap_scan_pkg::*;
  logic core_clk, rst, tck, trst_n, tms, tdi, debug_state_req, test_bus_tristate_n;
  logic addr_bus_enable, data_bus_enable, lock_value, read_write_n_value;
  logic translate_n_value, opcode_fetch_n_value, tdo, serial_out_enable_n;
  logic [31:0] data_bus_value, addr_bus_value, data_bus_out, addr_bus_out, din, dout;
  logic [1:0] transfer_size_value, transfer_size;
  logic [3:0] selected_chain_id, tap_state_out;
  logic ext_scan_reset_out, ext_scan_serial_in, ext_scan_serial_return, ret_q;
  logic ext_shift_clk_phase1, ext_shift_clk_phase2, test_clk_phase_one, test_clk_phase_two;
  logic debug_clk, data_bus_oe, addr_bus_oe, lock_out, read_write_n, translate_n;
  logic opcode_fetch_n, control_oe, core_test_reset;
  int num_errors, samples_checked, seed, i, j;

  tap_external_scan tap_external_scan_i (.*);
  ext_scan_cells ext_scan_cells_i (
    .reset_cells(ext_scan_reset_out),
    .shift_clk1(ext_shift_clk_phase1),
    .serial_in(ext_scan_serial_in),
    .serial_return(ext_scan_serial_return)
  );

  initial
  begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    tck = 0;
    #7;
    forever #32 tck = ~tck;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    @(posedge tck);
  endtask
  // from idle through one data or instruction scan and back to idle
  task automatic scan(input logic ir, input int n, input logic ext);
    step(1, 0);
    if (ir)
      step(1, 0);
    step(0, 0);
    step(0, 0);
    for (i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i]);
      dout[i] = tdo;
      if (ext && i > 0)
      begin
        chk(ext_scan_serial_in, din[i-1]);
        chk(tdo, ret_q);
      end
      ret_q = ext_scan_serial_return;
    end
    step(1, 0);
    step(0, 0);
  endtask
  task automatic end_of_test;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    seed = 32'hc06d_45a1;
    num_errors = 0;
    samples_checked = 0;
    rst = 1;
    trst_n = 0;
    tms = 1;
    tdi = 0;
    debug_state_req = 0;
    test_bus_tristate_n = 1;
    {addr_bus_enable, data_bus_enable, lock_value, read_write_n_value} = 4'h0;
    {translate_n_value, opcode_fetch_n_value, transfer_size_value} = 4'h0;
    data_bus_value = 32'h0000_0000;
    addr_bus_value = 32'h0000_0000;
    repeat (10) @(posedge core_clk);
    chk(ext_scan_reset_out, 1);
    chk(selected_chain_id, CHAIN_RESET_VALUE);
    rst <= 0;
    trst_n <= 1;
    @(posedge tck);
    step(0, 0);
    #1;
    chk(tap_state_out, ST_RUN_IDLE);
    chk(ext_scan_reset_out, 0);
    din = $random(seed);
    scan(0, 32, 0);
    chk(dout, IDCODE_DEFAULT);
    din = {28'h000_0000, INSTR_EXTEST};
    scan(1, 4, 0);
    chk(dout[3:0], IR_CAPTURE_VALUE);
    din = $random(seed);
    scan(0, 32, 1);
    din = {28'h000_0000, INSTR_SCAN_N};
    scan(1, 4, 0);
    for (j = 0; j < 4; j++)
    begin
      din = (j + 1) % 4;
      scan(0, 4, 0);
      chk(dout[3:0], j ? j : CHAIN_RESET_VALUE);
      chk(selected_chain_id, din[3:0]);
    end
    // abort a data scan with the test reset pin
    step(1, 0);
    step(0, 0);
    step(0, 0);
    trst_n <= 0;
    #5;
    chk(tap_state_out, ST_TEST_RESET);
    chk(selected_chain_id, CHAIN_RESET_VALUE);
    chk(serial_out_enable_n, 1);
    @(posedge core_clk);
    trst_n <= 1;
    @(posedge tck);
    step(0, 0);
    repeat (5) step(1, 0);
    #1;
    chk(tap_state_out, ST_TEST_RESET);
    chk(ext_scan_reset_out, 1);
    debug_state_req <= 1;
    repeat (4) @(posedge tck);
    #2;
    chk(debug_clk, 1);
    chk(test_clk_phase_two, 0);
    @(negedge tck);
    #2;
    chk(debug_clk, 0);
    chk(test_clk_phase_one, 0);
    debug_state_req <= 0;
    for (j = 0; j < 24; j++)
    begin
      @(posedge core_clk);
      test_bus_tristate_n <= j % 4 != 1;
      addr_bus_enable <= 1'($random(seed));
      data_bus_enable <= 1'($random(seed));
      data_bus_value <= $random(seed);
      addr_bus_value <= $random(seed);
      {lock_value, transfer_size_value, read_write_n_value, translate_n_value, opcode_fetch_n_value}
        <= 6'($random(seed));
      repeat (5) @(posedge core_clk);
      chk(data_bus_oe, test_bus_tristate_n && data_bus_enable);
      chk(addr_bus_oe, test_bus_tristate_n && addr_bus_enable);
      chk(core_test_reset, 1);
      chk(control_oe, test_bus_tristate_n && addr_bus_enable);
      if (test_bus_tristate_n)
      begin
        chk(data_bus_out, data_bus_value);
        chk(addr_bus_out, addr_bus_value);
        chk({lock_out, transfer_size, read_write_n, translate_n, opcode_fetch_n},
          {lock_value, transfer_size_value, read_write_n_value, translate_n_value, opcode_fetch_n_value});
      end
    end
    // float instruction must release the buses with the pin high
    data_bus_enable <= 1'b1;
    addr_bus_enable <= 1'b1;
    step(0, 0);
    din = {28'h000_0000, INSTR_HIGHZ};
    scan(1, 4, 0);
    chk(dout[3:0], IR_CAPTURE_VALUE);
    repeat (8) @(posedge core_clk);
    chk(data_bus_oe, 0);
    chk(addr_bus_oe, 0);
    chk(control_oe, 0);
    chk(core_test_reset, 0);
    end_of_test;
  end

  initial
  begin
    repeat (50000) @(posedge core_clk);
    num_errors++;
    end_of_test;
  end
endmodule
